// ### mscht_map.svh
// Register offsets, field positions and reset values of the statistics and hash block.
`ifndef MSCHT_MAP_SVH
`define MSCHT_MAP_SVH
`define MSCHT_IDX_BCAST_MCAST   8'h52
`define MSCHT_IDX_RUNT_CRC      8'h54
`define MSCHT_IDX_LONG          8'h56
`define MSCHT_IDX_FFULL_NODESC  8'h58
`define MSCHT_IDX_TX_GOOD       8'h5a
`define MSCHT_IDX_UNDR_LATE     8'h5c
`define MSCHT_IDX_PAUSE         8'h5e
`define MSCHT_IDX_HASH0         8'h60
`define MSCHT_IDX_HASH1         8'h62
`define MSCHT_IDX_HASH2         8'h64
`define MSCHT_IDX_HASH3         8'h66
`define MSCHT_IDX_INT_STATUS    8'h44
`define MSCHT_IDX_INT_MASK      8'h48
`define MSCHT_ADDR_BITS         10
`define MSCHT_NUM_EVENTS        12
`define MSCHT_NUM_HASH          4
`define MSCHT_TALLY_RESET       16'h0000
`define MSCHT_HASH_RESET        16'h0000
`define MSCHT_EV_RX_MCAST       0
`define MSCHT_EV_RX_BCAST       1
`define MSCHT_EV_RX_CRC         2
`define MSCHT_EV_RX_RUNT        3
`define MSCHT_EV_RX_LONG        4
`define MSCHT_EV_RX_NODESC      5
`define MSCHT_EV_RX_FFULL       6
`define MSCHT_EV_TX_GOOD        7
`define MSCHT_EV_TX_LATE        8
`define MSCHT_EV_TX_UNDR        9
`define MSCHT_EV_RX_PAUSE       10
`define MSCHT_EV_TX_PAUSE       11
`endif

// ### mscht_pkg.sv
// Types shared by the statistics and hash block.
package mscht_pkg;
    typedef struct packed {
        logic        rx_multicast;
        logic        rx_broadcast;
        logic        rx_crc_error;
        logic        rx_runt;
        logic        rx_oversize;
        logic        rx_no_descriptor;
        logic        rx_fifo_full;
        logic        tx_good;
        logic        tx_late_collision;
        logic        tx_underrun_drop;
        logic        rx_pause;
        logic        tx_pause;
    } mscht_events_s;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [9:0]  addr;
    } mscht_bus_req_s;
    typedef enum logic [1:0] {
        MSCHT_PH_IDLE,
        MSCHT_PH_READ,
        MSCHT_PH_WRITE
    } mscht_phase_e;
endpackage

// ### mscht_tally.sv
// One saturating read-to-clear event counter with a top-bit flag.
`timescale 1ns/100ps
`include "mscht_map.svh"
module mscht_tally #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input  wire logic             core_clk_in,
    input  wire logic             resetn_in,
    // Event and clear.
    input  wire logic             event_in,
    input  wire logic             clear_in,
    // Count and flag.
    output logic [WIDTH-1:0]      count_out,
    output logic                  msb_rise_out
);
    logic [WIDTH-1:0] count_ff;
    logic [WIDTH-1:0] nxt_count;
    logic [WIDTH-1:0] bumped;
    wire              at_max = &count_ff;

    assign bumped = at_max ? count_ff : count_ff + {{(WIDTH-1){1'b0}}, 1'b1}; // [R15]
    assign nxt_count = clear_in ? {{(WIDTH-1){1'b0}}, event_in} : (event_in ? bumped : count_ff); // [R13] [R19]
    assign msb_rise_out = nxt_count[WIDTH-1] & ~count_ff[WIDTH-1]; // [R16]
    assign count_out = count_ff;

    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
            count_ff <= '0; // [R18]
        else
            count_ff <= nxt_count;
    end
endmodule // mscht_tally

// ### mscht_hash_mem.sv
// Four-word multicast hash table with registered read data.
`timescale 1ns/100ps
`include "mscht_map.svh"
module mscht_hash_mem (
    // Clock and reset.
    input  wire logic         core_clk_in,
    input  wire logic         resetn_in,
    // Write port.
    input  wire logic         wr_en_in,
    input  wire logic [1:0]   wr_idx_in,
    input  wire logic [15:0]  wr_data_in,
    // Read port.
    input  wire logic [1:0]   rd_idx_in,
    output logic [15:0]       rd_data_out,
    output logic [63:0]       table_out
);
    logic [15:0] word_ff [`MSCHT_NUM_HASH];

    genvar g;
    generate
        for (g = 0; g < `MSCHT_NUM_HASH; g++)
        begin : g_word
            always_ff @(posedge core_clk_in)
            begin
                if (!resetn_in)
                    word_ff[g] <= `MSCHT_HASH_RESET; // [R18]
                else if (wr_en_in && wr_idx_in == 2'(g))
                    word_ff[g] <= wr_data_in; // [R14]
            end
            assign table_out[16*g +: 16] = word_ff[g];
        end
    endgenerate

    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
            rd_data_out <= 16'h0000;
        else
            rd_data_out <= word_ff[rd_idx_in];
    end
endmodule // mscht_hash_mem

// ### mscht_top.sv
// Statistics counters, counter interrupts and multicast hash table behind an AHB-Lite slave.
// Overview of operation
// [R1] Upper byte at 52h counts received broadcast packets.
// [R2] Lower byte at 52h counts received multicast packets.
// [R3] Upper byte at 54h counts received runt packets.
// [R4] Lower byte at 54h counts received CRC error packets.
// [R5] Lower byte at 56h counts over-length packets; upper byte reserved.
// [R6] Upper byte at 58h counts packets hit by receive FIFO full.
// [R7] Lower byte at 58h counts packets lost for lack of descriptor.
// [R8] Whole 16 bits at 5Ah count good transmitted packets.
// [R9] Upper byte at 5Ch counts transmit underrun drops.
// [R10] Lower byte at 5Ch counts late collision transmit packets.
// [R11] Upper byte at 5Eh counts transmitted pause frames.
// [R12] Lower byte at 5Eh counts received pause frames.
// [R13] Reading a counter register returns the count then zeroes it.
// [R14] Hash table is four read/write 16-bit words at 60h to 66h.
// [R15] Counters stop at 255 or 65535 instead of wrapping.
// [R16] A counter's status flag sets when its top bit becomes one.
// [R17] Reading a counter register clears its status flags.
// [R18] Reset zeroes every counter and hash word.
// [R19] An event during the clearing read leaves a count of one.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/100ps
`include "mscht_map.svh"
module mscht_top (
    // Clock and reset.
    input  wire logic                   core_clk_in,
    input  wire logic                   resetn_in,
    // AHB-Lite slave.
    input  wire logic                   hsel_in,
    input  wire logic [31:0]            haddr_in,
    input  wire logic [1:0]             htrans_in,
    input  wire logic                   hwrite_in,
    input  wire logic [2:0]             hsize_in,
    input  wire logic                   hready_in,
    input  wire logic [31:0]            hwdata_in,
    output logic [31:0]                 hrdata_out,
    output logic                        hreadyout_out,
    output logic                        hresp_out,
    // Packet events, one-cycle pulses from the MAC.
    input  wire mscht_pkg::mscht_events_s events_in,
    // Filter table and interrupt.
    output logic [63:0]                 hash_table_out,
    output logic                        irq_out
);
    localparam int NE = `MSCHT_NUM_EVENTS;

    function automatic logic [3:0] reg_slot(input logic [9:0] a);
        unique case (a[9:2])
            `MSCHT_IDX_BCAST_MCAST:  reg_slot = 4'h0;
            `MSCHT_IDX_RUNT_CRC:     reg_slot = 4'h1;
            `MSCHT_IDX_LONG:         reg_slot = 4'h2;
            `MSCHT_IDX_FFULL_NODESC: reg_slot = 4'h3;
            `MSCHT_IDX_TX_GOOD:      reg_slot = 4'h4;
            `MSCHT_IDX_UNDR_LATE:    reg_slot = 4'h5;
            `MSCHT_IDX_PAUSE:        reg_slot = 4'h6;
            `MSCHT_IDX_HASH0:        reg_slot = 4'h7;
            `MSCHT_IDX_HASH1:        reg_slot = 4'h8;
            `MSCHT_IDX_HASH2:        reg_slot = 4'h9;
            `MSCHT_IDX_HASH3:        reg_slot = 4'ha;
            `MSCHT_IDX_INT_STATUS:   reg_slot = 4'hb;
            `MSCHT_IDX_INT_MASK:     reg_slot = 4'hc;
            default:                 reg_slot = 4'hf;
        endcase
    endfunction

    // Counter register slot that owns each event.
    function automatic logic [3:0] ev_slot(input int e);
        ev_slot = 4'(e / 2);
        if (e == `MSCHT_EV_TX_GOOD)
            ev_slot = 4'h4;
        else if (e > `MSCHT_EV_TX_GOOD)
            ev_slot = 4'((e + 2) / 2);
        else if (e == `MSCHT_EV_RX_LONG)
            ev_slot = 4'h2;
        else if (e > `MSCHT_EV_RX_LONG)
            ev_slot = 4'h3;
    endfunction

    logic [NE-1:0]          ev_vec;
    logic [NE-1:0]          clr_vec;
    logic [NE-1:0]          msb_rise;
    logic [7:0]             tally8 [NE];
    logic [15:0]            tx_good_count;
    logic [NE-1:0]          status_ff;
    logic [NE-1:0]          nxt_status;
    logic [NE-1:0]          mask_ff;
    mscht_pkg::mscht_bus_req_s req_ff;
    mscht_pkg::mscht_phase_e   phase;
    logic [31:0]            rdata_ff;
    logic [31:0]            nxt_rdata;
    logic [15:0]            hash_rd;
    logic [3:0]             rd_slot_ff;
    logic [3:0]             addr_slot;
    logic [3:0]             req_slot;
    logic                   take;
    logic                   rd_now;
    logic                   wr_now;
    logic [15:0]            status_word;
    logic [15:0]            counter_word;
    logic                   hash_rd_sel;

    // Event vector in counter order.
    assign ev_vec = {events_in.tx_pause, events_in.rx_pause, events_in.tx_underrun_drop,
                     events_in.tx_late_collision, events_in.tx_good, events_in.rx_fifo_full,
                     events_in.rx_no_descriptor, events_in.rx_oversize, events_in.rx_runt,
                     events_in.rx_crc_error, events_in.rx_broadcast, events_in.rx_multicast};

    // Bus decode.
    assign take      = hsel_in & hready_in & htrans_in[1];
    assign addr_slot = reg_slot(haddr_in[9:0]);
    assign req_slot  = reg_slot(req_ff.addr);
    assign phase     = !req_ff.valid ? mscht_pkg::MSCHT_PH_IDLE :
                       (req_ff.write ? mscht_pkg::MSCHT_PH_WRITE : mscht_pkg::MSCHT_PH_READ);
    assign rd_now    = take & ~hwrite_in;
    assign wr_now    = phase == mscht_pkg::MSCHT_PH_WRITE;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = hash_rd_sel ? {16'h0000, hash_rd} : rdata_ff; // [R14]

    // Counters, cleared by the read address phase so the registered data hold the old count.
    genvar g;
    generate
        for (g = 0; g < NE; g++)
        begin : g_tally
            assign clr_vec[g] = rd_now && addr_slot == ev_slot(g); // [R13]
            if (g == `MSCHT_EV_TX_GOOD)
            begin : g_wide
                mscht_tally #(.WIDTH(16)) u_tally ( // [R8]
                    .core_clk_in  (core_clk_in),
                    .resetn_in    (resetn_in),
                    .event_in     (ev_vec[g]),
                    .clear_in     (clr_vec[g]),
                    .count_out    (tx_good_count),
                    .msb_rise_out (msb_rise[g])
                );
                assign tally8[g] = 8'h00;
            end
            else
            begin : g_narrow
                mscht_tally #(.WIDTH(8)) u_tally (
                    .core_clk_in  (core_clk_in),
                    .resetn_in    (resetn_in),
                    .event_in     (ev_vec[g]),
                    .clear_in     (clr_vec[g]),
                    .count_out    (tally8[g]),
                    .msb_rise_out (msb_rise[g])
                );
            end
        end
    endgenerate

    // Sticky flags: set wins over the clear by a counter read or a status read.
    assign nxt_status = msb_rise | (status_ff & ~clr_vec
                        & ~{NE{rd_now && addr_slot == 4'hb}}); // [R16] [R17]
    assign irq_out = |(status_ff & mask_ff);

    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            status_ff <= '0;
            mask_ff   <= '0;
        end
        else
        begin
            status_ff <= nxt_status;
            if (wr_now && req_slot == 4'hc)
                mask_ff <= hwdata_in[NE-1:0];
        end
    end

    mscht_hash_mem u_hash (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .wr_en_in    (wr_now && req_slot >= 4'h7 && req_slot <= 4'ha), // [R14]
        .wr_idx_in   (req_ff.addr[4:3]),
        .wr_data_in  (hwdata_in[15:0]),
        .rd_idx_in   (haddr_in[4:3]),
        .rd_data_out (hash_rd),
        .table_out   (hash_table_out)
    );

    // Read mux, sampled at the address phase.
    always_comb
    begin
        unique case (addr_slot)
            4'h0:    counter_word = {tally8[`MSCHT_EV_RX_BCAST], tally8[`MSCHT_EV_RX_MCAST]}; // [R1] [R2]
            4'h1:    counter_word = {tally8[`MSCHT_EV_RX_RUNT], tally8[`MSCHT_EV_RX_CRC]}; // [R3] [R4]
            4'h2:    counter_word = {8'h00, tally8[`MSCHT_EV_RX_LONG]}; // [R5]
            4'h3:    counter_word = {tally8[`MSCHT_EV_RX_FFULL], tally8[`MSCHT_EV_RX_NODESC]}; // [R6] [R7]
            4'h4:    counter_word = tx_good_count;
            4'h5:    counter_word = {tally8[`MSCHT_EV_TX_UNDR], tally8[`MSCHT_EV_TX_LATE]}; // [R9] [R10]
            4'h6:    counter_word = {tally8[`MSCHT_EV_TX_PAUSE], tally8[`MSCHT_EV_RX_PAUSE]}; // [R11] [R12]
            4'hb:    counter_word = 16'(status_ff);
            4'hc:    counter_word = 16'(mask_ff);
            default: counter_word = 16'h0000;
        endcase
    end
    assign status_word = counter_word;
    assign nxt_rdata = rd_now ? {16'h0000, status_word} : 32'h00000000;

    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            req_ff     <= '0;
            rdata_ff   <= 32'h00000000;
            rd_slot_ff <= 4'hf;
        end
        else
        begin
            req_ff.valid <= take;
            req_ff.write <= hwrite_in;
            req_ff.addr  <= haddr_in[9:0];
            rdata_ff     <= nxt_rdata;
            rd_slot_ff   <= rd_now ? addr_slot : 4'hf;
        end
    end
    // Hash words come from the memory's registered read port.
    assign hash_rd_sel = rd_slot_ff >= 4'h7 && rd_slot_ff <= 4'ha; // [R14]
endmodule // mscht_top

// ### mscht_monitor.sv
// Port checker of the statistics and hash block.
`timescale 1ns/100ps
module mscht_monitor (
    // Clock and reset.
    input wire logic                     core_clk_in,
    input wire logic                     resetn_in,
    // Register bus.
    input wire logic                     hsel_in,
    input wire logic [31:0]              haddr_in,
    input wire logic [1:0]               htrans_in,
    input wire logic                     hwrite_in,
    input wire logic [2:0]               hsize_in,
    input wire logic                     hready_in,
    input wire logic [31:0]              hwdata_in,
    input wire logic [31:0]              hrdata_out,
    input wire logic                     hreadyout_out,
    input wire logic                     hresp_out,
    // Events, table and interrupt.
    input wire mscht_pkg::mscht_events_s events_in,
    input wire logic [63:0]              hash_table_out,
    input wire logic                     irq_out
);
    logic        aph;
    logic        noev;
    logic [7:0]  idx;
    logic        hash_dp_ff;
    logic        mask_dp_ff;
    logic [11:0] mask_ff;
    assign aph = hsel_in && hready_in && htrans_in[1];
    assign idx = haddr_in[9:2];
    assign noev = (events_in == 12'h000);
    always_ff @(posedge core_clk_in)
    begin
        hash_dp_ff <= resetn_in && aph && hwrite_in && idx[7:3] == 5'h0c && !idx[0];
        mask_dp_ff <= resetn_in && aph && hwrite_in && idx == 8'h48;
        mask_ff <= !resetn_in ? 12'h000 : (mask_dp_ff ? hwdata_in[11:0] : mask_ff);
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    AST_OKAY: assert property (hresp_out == 1'b0)
        else $error("bus response not okay");
    AST_RESET_CLEAR: assert property (disable iff (1'b0) !resetn_in |=> hash_table_out == 64'h0 && !irq_out)
        else $error("reset left state behind");
    AST_HASH_WORD0: assert property (aph && hwrite_in && idx == 8'h60 |=> 1'b1 ##1 hash_table_out[15:0] == $past(hwdata_in[15:0]))
        else $error("hash word write lost");
    AST_HASH_HOLD: assert property (!$past(hash_dp_ff) |-> $stable(hash_table_out))
        else $error("hash table changed without write");
    AST_MASKED_QUIET: assert property (mask_ff == 12'h000 && $past(mask_ff) == 12'h000 |-> !irq_out)
        else $error("interrupt while fully masked");
    AST_UNMAPPED: assert property (aph && !hwrite_in && idx >= 8'h68 |=> hrdata_out == 32'h0)
        else $error("unmapped read not zero");
    AST_RSVD_BYTE: assert property (aph && !hwrite_in && idx == 8'h56 |=> hrdata_out[15:8] == 8'h00)
        else $error("reserved byte not zero");
    AST_CLEAR_ZERO: assert property ((aph && !hwrite_in && idx == 8'h52 && noev) ##1 noev ##1 (aph && !hwrite_in && idx == 8'h52) |=> hrdata_out[15:0] == 16'h0)
        else $error("counter not cleared by read");
    AST_STATUS_CLEAR: assert property ((aph && !hwrite_in && idx == 8'h44 && noev) ##1 noev |=> !irq_out)
        else $error("interrupt held after status read");
    cover property (aph && !hwrite_in && idx == 8'h44);
    cover property (irq_out);
    cover property (aph && hwrite_in && idx == 8'h66);
endmodule // mscht_monitor
bind mscht_top mscht_monitor u_mscht_monitor (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hready_in(hready_in),
    .hwdata_in(hwdata_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .events_in(events_in), .hash_table_out(hash_table_out), .irq_out(irq_out));

// ### testbench.sv
// Self-checking bench of the statistics and hash block.
`timescale 1ns/100ps
module testbench;
    logic        core_clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        hsel_in = 1'b0;
    logic        hwrite_in = 1'b0;
    logic        hreadyout_out;
    logic        hresp_out;
    logic        irq_out;
    logic [1:0]  htrans_in = 2'h0;
    logic [31:0] haddr_in = 32'h0;
    logic [31:0] hwdata_in = 32'h0;
    logic [31:0] hrdata_out;
    logic [31:0] seed = 32'h47;
    logic [63:0] hash_table_out;
    logic [11:0] flags;
    logic [11:0] mask;
    logic [15:0] hash [4];
    int          bad_count = 0;
    int          checked = 0;
    int          cnt [12];
    int          rg [12] = '{8'h52, 8'h52, 8'h54, 8'h54, 8'h56, 8'h58, 8'h58, 8'h5a, 8'h5c, 8'h5c, 8'h5e, 8'h5e};
    int          sh [12] = '{0, 8, 0, 8, 0, 0, 8, 0, 0, 8, 0, 8};
    mscht_pkg::mscht_events_s events_in = '0;
    always #2 core_clk_in = ~core_clk_in;
    mscht_top u_mscht_top (
        .core_clk_in(core_clk_in), .resetn_in(resetn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hready_in(hreadyout_out),
        .hwdata_in(hwdata_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .events_in(events_in), .hash_table_out(hash_table_out), .irq_out(irq_out));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic mscht_pkg::mscht_events_s rev(input logic [11:0] ev);
        logic [11:0] r;
        for (int i = 0; i < 12; i++)
            r[11 - i] = ev[i];
        return r;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic model_ev(input logic [11:0] ev);
        int mx;
        for (int i = 0; i < 12; i++)
        begin
            mx = (i == 7) ? 65535 : 255;
            if (ev[i] && cnt[i] < mx)
                cnt[i]++;
            if (ev[i] && cnt[i] == mx / 2 + 1)
                flags[i] = 1'b1;
        end
    endtask
    task automatic tick(input logic [11:0] ev);
        events_in <= rev(ev);
        model_ev(ev);
        @(posedge core_clk_in);
    endtask
    task automatic access(input logic wr, input logic [7:0] idx, input logic [15:0] wd, input logic [11:0] ev);
        logic [15:0] v;
        v = 16'h0000;
        hsel_in <= 1'b1;
        haddr_in <= {22'h0, idx, 2'b00};
        htrans_in <= 2'b10;
        hwrite_in <= wr;
        events_in <= rev(ev);
        do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'b00;
        hwdata_in <= {16'h0, wd};
        events_in <= '0;
        for (int i = 0; i < 12; i++)
            if (rg[i] == idx && !wr)
            begin
                v = v | 16'(cnt[i] << sh[i]);
                cnt[i] = 0;
                flags[i] = 1'b0;
            end
        if (idx == 8'h44 && !wr)
        begin
            v = {4'h0, flags};
            flags = 12'h000;
        end
        if (idx == 8'h48 && wr)
            mask = wd[11:0];
        if (idx == 8'h48)
            v = {4'h0, mask};
        if (idx[7:3] == 5'h0c && !idx[0] && wr)
            hash[idx[2:1]] = wd;
        if (idx[7:3] == 5'h0c && !idx[0])
            v = hash[idx[2:1]];
        model_ev(ev);
        do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
        if (!wr)
            chk(hrdata_out, {16'h0, v});
    endtask
    task automatic reset_all;
        resetn_in <= 1'b0;
        for (int i = 0; i < 12; i++)
            cnt[i] = 0;
        flags = 12'h000;
        mask = 12'h000;
        hash = '{default: 16'h0};
        repeat (5) @(posedge core_clk_in);
        resetn_in <= 1'b1;
    endtask
    task automatic results;
        if (bad_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        reset_all();
        for (int a = 8'h44; a < 8'h72; a += 2)
            access(1'b0, 8'(a), 16'h0, 12'h0);
        access(1'b1, 8'h70, 16'hffff, 12'h0);
        access(1'b0, 8'h70, 16'h0, 12'h0);
        repeat (300)
        begin
            seed = xs(seed);
            tick(seed[11:0]);
        end
        access(1'b0, 8'h5a, 16'h0, 12'h0);
        access(1'b1, 8'h5a, 16'h1234, 12'h0);
        repeat (2) tick(12'h0);
        chk({31'h0, irq_out}, {31'h0, |(flags & mask)});
        access(1'b1, 8'h48, 16'h0fff, 12'h0);
        repeat (2) tick(12'h0);
        chk({31'h0, irq_out}, {31'h0, |(flags & mask)});
        access(1'b0, 8'h52, 16'h0, 12'h0);
        access(1'b0, 8'h52, 16'h0, 12'h0);
        access(1'b0, 8'h44, 16'h0, 12'h0);
        repeat (2) tick(12'h0);
        chk({31'h0, irq_out}, {31'h0, |(flags & mask)});
        for (int a = 8'h52; a < 8'h60; a += 2)
            access(1'b0, 8'(a), 16'h0, 12'h0);
        access(1'b0, 8'h52, 16'h0, 12'h0);
        repeat (260) tick(12'hfff);
        access(1'b0, 8'h54, 16'h0, 12'hfff);
        for (int a = 8'h52; a < 8'h60; a += 2)
            access(1'b0, 8'(a), 16'h0, 12'h0);
        for (int w = 0; w < 4; w++)
        begin
            seed = xs(seed);
            access(1'b1, 8'h60 + 8'(2 * w), seed[15:0], 12'h0);
        end
        for (int w = 0; w < 4; w++)
            access(1'b0, 8'h60 + 8'(2 * w), 16'h0, 12'h0);
        chk(hash_table_out[31:0], {hash[1], hash[0]});
        chk(hash_table_out[63:32], {hash[3], hash[2]});
        reset_all();
        for (int a = 8'h52; a < 8'h68; a += 2)
            access(1'b0, 8'(a), 16'h0, 12'h0);
        results();
    end
    initial
    begin
        #20000;
        bad_count++;
        results();
    end
endmodule // testbench
